/* File: rtl/scp_consts.vh */
`ifndef SCP_CONSTS_VH
`define SCP_CONSTS_VH
// ****************************************
// Word format
// ****************************************
`define SCP_WORD_BITS 5'd24
`define SCP_ADDR_BITS 5'd16
`define SCP_CNT_LAST 5'd23
`define SCP_CNT_ADDR 5'd15
`define SCP_BIT_RW 23
`define SCP_BIT_FIX 22
// ****************************************
// Register offsets
// ****************************************
`define SCP_DITHER_DISABLE_CTRL 14'h0001
`define SCP_CHAN_A_GAIN_ENABLE 14'h0003
`define SCP_CHAN_B_GAIN_ENABLE 14'h0004
`define SCP_PATTERN_ENABLE_SOFT_RESET 14'h0006
`define SCP_CHAN_A_SPECIAL_FAST_OVR 14'h0007
`define SCP_CHAN_B_SPECIAL_SELECT 14'h0008
`define SCP_PATTERN_ALIGN_FORMAT 14'h0009
`define SCP_CHAN_A_PATTERN_SELECT 14'h000a
`define SCP_CHAN_B_PATTERN_SELECT 14'h000b
`define SCP_CHAN_A_GAIN_SETTING 14'h000c
`define SCP_CHAN_B_GAIN_SETTING 14'h000d
`define SCP_USER_PATTERN_HIGH 14'h000e
`define SCP_USER_PATTERN_LOW 14'h000f
`define SCP_SLOW_RATE_SELECT 14'h0013
`define SCP_POWER_DOWN_CTRL 14'h0015
`define SCP_CLOCK_DIVIDER_SELECT 14'h0027
`define SCP_SERIAL_LINK_CTRL 14'h002a
`define SCP_LANE_PARAM_SELECT 14'h002b
`define SCP_SCRAMBLER_CTRL 14'h002f
`define SCP_OCTETS_PER_FRAME_CFG 14'h0030
`define SCP_FRAMES_PER_MF_CFG 14'h0031
`define SCP_NUM_REGS 21
`define SCP_REG_RESET 8'h00
// ****************************************
// Field positions
// ****************************************
`define SCP_SOFT_RESET_BIT 0
`define SCP_GAIN_EN_BIT 1
`define SCP_FAST_OVR_SEL_BIT 1
`define SCP_GAIN_MAX 4'hc
// ****************************************
// Overrange and timing
// ****************************************
`define SCP_MAX_CODE 16'h3fff
`define SCP_FAST_OVR_LAT 9
`define SCP_CLK_NS 100
`define SCP_RST_MIN_NS 10
`define SCP_RST_MIN_CYC 1
`define SCP_RST_MAX_NS 1000
`define SCP_RST_MAX_CYC (`SCP_RST_MAX_NS / `SCP_CLK_NS)
`define SCP_SEN_DELAY_NS 100
`define SCP_SEN_DELAY_CYC ((`SCP_SEN_DELAY_NS + `SCP_CLK_NS - 1) / `SCP_CLK_NS)
`endif

/* File: rtl/scp_sync.v */
`timescale 1ns/100ps
module scp_sync #(
    parameter W = 1,
    parameter [W-1:0] INIT = {W{1'b0}}
) (
    clk,
    reset,
    d,
    q
);
    input wire clk;
    input wire reset;
    input wire [W-1:0] d;
    output reg [W-1:0] q;
    reg [W-1:0] meta_q;
    always @(posedge clk) begin
        if (reset) begin
            meta_q <= INIT;
            q <= INIT;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // scp_sync

/* File: rtl/scp_ovr_path.v */
`timescale 1ns/100ps
`include "scp_consts.vh"
module scp_ovr_path (
    clk,
    reset,
    sample_tick,
    raw_in,
    gain_code,
    threshold,
    fast_sel,
    ovr_out
);
    input wire clk;
    input wire reset;
    input wire sample_tick;
    input wire [15:0] raw_in;
    input wire [3:0] gain_code;
    input wire [15:0] threshold;
    input wire fast_sel;
    output reg ovr_out;
    reg [9:0] mult;
    wire [25:0] prod;
    reg norm_q;
    reg [`SCP_FAST_OVR_LAT-1:0] fast_q;
    // ****************************************
    // Gain in 0.5 dB steps, Q8 factors
    // ****************************************
    always @* begin
        case (gain_code)
            4'h0: mult = 10'd256;
            4'h1: mult = 10'd271;
            4'h2: mult = 10'd287;
            4'h3: mult = 10'd304;
            4'h4: mult = 10'd323;
            4'h5: mult = 10'd342;
            4'h6: mult = 10'd362;
            4'h7: mult = 10'd383;
            4'h8: mult = 10'd406;
            4'h9: mult = 10'd430;
            4'ha: mult = 10'd456;
            4'hb: mult = 10'd483;
            default: mult = 10'd511;
        endcase
    end
    assign prod = raw_in * mult;
    always @(posedge clk) begin
        if (reset) begin
            norm_q <= 1'b0;
            fast_q <= {`SCP_FAST_OVR_LAT{1'b0}};
            ovr_out <= 1'b0;
        end else begin
            if (sample_tick) begin
                norm_q <= (prod[25:8] > {2'b00, `SCP_MAX_CODE});
                fast_q <= {fast_q[`SCP_FAST_OVR_LAT-2:0], raw_in > threshold};
            end
            ovr_out <= fast_sel ? fast_q[`SCP_FAST_OVR_LAT-1] : norm_q;
        end
    end
endmodule // scp_ovr_path

/* File: rtl/scp_top.v */
`timescale 1ns/100ps
`include "scp_consts.vh"
module scp_top (
    clk,
    reset,
    shift_clk,
    port_select_low,
    port_serial_in,
    port_serial_out,
    port_serial_out_oe_n,
    sample_tick,
    raw_a,
    raw_b,
    fast_ovr_threshold,
    overrange_out_a,
    overrange_out_b
);
    input wire clk;
    input wire reset;
    input wire shift_clk;
    input wire port_select_low;
    input wire port_serial_in;
    output reg port_serial_out;
    output reg port_serial_out_oe_n;
    input wire sample_tick;
    input wire [15:0] raw_a;
    input wire [15:0] raw_b;
    input wire [15:0] fast_ovr_threshold;
    output wire overrange_out_a;
    output wire overrange_out_b;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    wire [2:0] pins_s;
    wire sclk_s;
    wire sel_s;
    wire din_s;
    reg sclk_prev_q;
    wire sclk_rise;
    wire sclk_fall;

    // Two flops per pin; the shift clock is sampled, never used as a clock
    // Select idles high so a reset never opens a frame
    scp_sync #(
        .W(3),
        .INIT(3'b010)
    ) u_pin_sync (
        .clk(clk),
        .reset(reset),
        .d({shift_clk, port_select_low, port_serial_in}),
        .q(pins_s)
    );

    assign sclk_s = pins_s[2];
    assign sel_s = pins_s[1];
    assign din_s = pins_s[0];
    // The edge detector resets to the idle low level, so reset makes no edge
    assign sclk_rise = sclk_s & ~sclk_prev_q;
    assign sclk_fall = ~sclk_s & sclk_prev_q;

    always @(posedge clk) begin
        if (reset) begin
            sclk_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= sclk_s;
        end
    end

    // ****************************************
    // Register decode
    // ****************************************
    // Storage slot of each mapped register; a decode hit adds bit 5
    // Converter setup
    localparam [4:0] IDX_DITHER_CTRL = 5'h00;
    localparam [4:0] IDX_A_GAIN_EN = 5'h01;
    localparam [4:0] IDX_B_GAIN_EN = 5'h02;
    localparam [4:0] IDX_PAT_SOFT_RST = 5'h03;
    localparam [4:0] IDX_A_SPECIAL_FOVR = 5'h04;
    localparam [4:0] IDX_B_SPECIAL = 5'h05;
    // Test patterns and gain
    localparam [4:0] IDX_PAT_ALIGN_FMT = 5'h06;
    localparam [4:0] IDX_A_PAT_SEL = 5'h07;
    localparam [4:0] IDX_B_PAT_SEL = 5'h08;
    localparam [4:0] IDX_A_GAIN_SET = 5'h09;
    localparam [4:0] IDX_B_GAIN_SET = 5'h0a;
    localparam [4:0] IDX_USER_PAT_HI = 5'h0b;
    localparam [4:0] IDX_USER_PAT_LO = 5'h0c;
    // Rate, power and clock
    localparam [4:0] IDX_SLOW_RATE = 5'h0d;
    localparam [4:0] IDX_POWER_DOWN = 5'h0e;
    localparam [4:0] IDX_CLK_DIV = 5'h0f;
    // Serial link
    localparam [4:0] IDX_LINK_CTRL = 5'h10;
    localparam [4:0] IDX_LANE_PARAM = 5'h11;
    localparam [4:0] IDX_SCRAMBLER = 5'h12;
    localparam [4:0] IDX_OCTETS_FRAME = 5'h13;
    localparam [4:0] IDX_FRAMES_MF = 5'h14;

    // Returns {valid, index}; unmapped addresses read zero, ignore writes
    function [5:0] reg_index;
        input [13:0] a;
        begin
            if (a == `SCP_DITHER_DISABLE_CTRL) begin
                reg_index = {1'b1, IDX_DITHER_CTRL};
            end else if (a == `SCP_CHAN_A_GAIN_ENABLE) begin
                reg_index = {1'b1, IDX_A_GAIN_EN};
            end else if (a == `SCP_CHAN_B_GAIN_ENABLE) begin
                reg_index = {1'b1, IDX_B_GAIN_EN};
            end else if (a == `SCP_PATTERN_ENABLE_SOFT_RESET) begin
                reg_index = {1'b1, IDX_PAT_SOFT_RST};
            end else if (a == `SCP_CHAN_A_SPECIAL_FAST_OVR) begin
                reg_index = {1'b1, IDX_A_SPECIAL_FOVR};
            end else if (a == `SCP_CHAN_B_SPECIAL_SELECT) begin
                reg_index = {1'b1, IDX_B_SPECIAL};
            end else if (a == `SCP_PATTERN_ALIGN_FORMAT) begin
                reg_index = {1'b1, IDX_PAT_ALIGN_FMT};
            end else if (a == `SCP_CHAN_A_PATTERN_SELECT) begin
                reg_index = {1'b1, IDX_A_PAT_SEL};
            end else if (a == `SCP_CHAN_B_PATTERN_SELECT) begin
                reg_index = {1'b1, IDX_B_PAT_SEL};
            end else if (a == `SCP_CHAN_A_GAIN_SETTING) begin
                reg_index = {1'b1, IDX_A_GAIN_SET};
            end else if (a == `SCP_CHAN_B_GAIN_SETTING) begin
                reg_index = {1'b1, IDX_B_GAIN_SET};
            end else if (a == `SCP_USER_PATTERN_HIGH) begin
                reg_index = {1'b1, IDX_USER_PAT_HI};
            end else if (a == `SCP_USER_PATTERN_LOW) begin
                reg_index = {1'b1, IDX_USER_PAT_LO};
            end else if (a == `SCP_SLOW_RATE_SELECT) begin
                reg_index = {1'b1, IDX_SLOW_RATE};
            end else if (a == `SCP_POWER_DOWN_CTRL) begin
                reg_index = {1'b1, IDX_POWER_DOWN};
            end else if (a == `SCP_CLOCK_DIVIDER_SELECT) begin
                reg_index = {1'b1, IDX_CLK_DIV};
            end else if (a == `SCP_SERIAL_LINK_CTRL) begin
                reg_index = {1'b1, IDX_LINK_CTRL};
            end else if (a == `SCP_LANE_PARAM_SELECT) begin
                reg_index = {1'b1, IDX_LANE_PARAM};
            end else if (a == `SCP_SCRAMBLER_CTRL) begin
                reg_index = {1'b1, IDX_SCRAMBLER};
            end else if (a == `SCP_OCTETS_PER_FRAME_CFG) begin
                reg_index = {1'b1, IDX_OCTETS_FRAME};
            end else if (a == `SCP_FRAMES_PER_MF_CFG) begin
                reg_index = {1'b1, IDX_FRAMES_MF};
            end else begin
                reg_index = 6'h00;
            end
        end
    endfunction

    // ****************************************
    // Receive shifter
    // ****************************************
    reg [7:0] regs_q [0:`SCP_NUM_REGS-1];
    reg [22:0] sh_q;
    reg [4:0] cnt_q;
    reg rd_mode_q;
    reg [7:0] out_sh_q;
    wire [23:0] word;
    wire [15:0] head;
    wire word_rw;
    wire [13:0] word_addr;
    wire [7:0] word_data;
    wire head_rw;
    wire [13:0] head_addr;
    wire [5:0] wr_idx;
    wire [5:0] rd_idx;
    wire [7:0] rd_data;
    wire word_done;
    wire head_done;
    wire wr_en;
    wire soft_reset;
    wire out_step;
    integer i;

    // Words are MSB first, so the newest bit is always the LSB
    assign word = {sh_q, din_s};
    assign head = {sh_q[14:0], din_s};
    assign word_rw = word[`SCP_BIT_RW];
    // A14 is carried but not checked; a host that clears it still gets through
    assign word_addr = word[21:8];
    assign word_data = word[7:0];
    assign head_rw = head[15];
    assign head_addr = head[13:0];
    assign wr_idx = reg_index(word_addr);
    assign rd_idx = reg_index(head_addr);
    assign rd_data = rd_idx[5] ? regs_q[rd_idx[4:0]] : 8'h00;
    assign word_done = sclk_rise & ~sel_s & (cnt_q == `SCP_CNT_LAST);
    assign head_done = sclk_rise & ~sel_s & (cnt_q == `SCP_CNT_ADDR);
    // A write word clears readout only after its address, so the same word
    // that drops the flag may also write
    assign wr_en = word_done & ~word_rw & ~rd_mode_q & wr_idx[5];
    assign soft_reset = wr_en & (word_addr == `SCP_PATTERN_ENABLE_SOFT_RESET)
        & word_data[`SCP_SOFT_RESET_BIT];
    // Readout bits only move inside a frame, so a deselected clock leaves the pin alone
    assign out_step = sclk_fall & ~sel_s & rd_mode_q;

    always @(posedge clk) begin
        if (reset) begin
            sh_q <= 23'h00_0000;
        end else if (sel_s) begin
            // Select high discards any partial word
            sh_q <= 23'h00_0000;
        end else if (sclk_rise) begin
            sh_q <= word[22:0];
        end
    end

    // The counter wraps at each full word, so words may follow back to back
    always @(posedge clk) begin
        if (reset) begin
            cnt_q <= 5'h00;
        end else if (sel_s) begin
            cnt_q <= 5'h00;
        end else if (sclk_rise) begin
            if (cnt_q == `SCP_CNT_LAST) begin
                cnt_q <= 5'h00;
            end else begin
                cnt_q <= cnt_q + 5'h01;
            end
        end
    end

    // ****************************************
    // Register bank
    // ****************************************
    always @(posedge clk) begin
        if (reset || soft_reset) begin
            for (i = 0; i < `SCP_NUM_REGS; i = i + 1) begin
                regs_q[i] <= `SCP_REG_RESET;
            end
        end else if (wr_en) begin
            regs_q[wr_idx[4:0]] <= word_data;
        end
    end

    // ****************************************
    // Readout
    // ****************************************
    always @(posedge clk) begin
        if (reset) begin
            rd_mode_q <= 1'b0;
            port_serial_out_oe_n <= 1'b1;
            out_sh_q <= 8'h00;
            port_serial_out <= 1'b0;
        end else begin
            // Readout outlives the frame; only reset or a word with the flag clear ends it
            if (head_done) begin
                rd_mode_q <= head_rw;
                port_serial_out_oe_n <= ~head_rw;
                out_sh_q <= rd_data;
            end else if (out_step) begin
                port_serial_out <= out_sh_q[7];
                out_sh_q <= {out_sh_q[6:0], 1'b0};
            end
        end
    end

    // ****************************************
    // Gain and overrange
    // ****************************************
    wire [7:0] gen_a;
    wire [7:0] gen_b;
    wire [3:0] gset_a;
    wire [3:0] gset_b;
    reg [3:0] gain_a;
    reg [3:0] gain_b;
    wire fast_sel;

    assign gen_a = regs_q[IDX_A_GAIN_EN];
    assign gen_b = regs_q[IDX_B_GAIN_EN];
    assign gset_a = regs_q[IDX_A_GAIN_SET][3:0];
    // Channel B keeps its gain code in the upper nibble
    assign gset_b = regs_q[IDX_B_GAIN_SET][7:4];
    assign fast_sel = regs_q[IDX_A_SPECIAL_FOVR][`SCP_FAST_OVR_SEL_BIT];
    // Codes above 6 dB are not defined; clamp them at the top step
    always @* begin
        if (!gen_a[`SCP_GAIN_EN_BIT]) begin
            gain_a = 4'h0;
        end else if (gset_a > `SCP_GAIN_MAX) begin
            gain_a = `SCP_GAIN_MAX;
        end else begin
            gain_a = gset_a;
        end
    end

    always @* begin
        if (!gen_b[`SCP_GAIN_EN_BIT]) begin
            gain_b = 4'h0;
        end else if (gset_b > `SCP_GAIN_MAX) begin
            gain_b = `SCP_GAIN_MAX;
        end else begin
            gain_b = gset_b;
        end
    end

    // Both channels share the threshold and the fast select bit
    scp_ovr_path u_ovr_a (
        .clk(clk),
        .reset(reset),
        .sample_tick(sample_tick),
        .raw_in(raw_a),
        .gain_code(gain_a),
        .threshold(fast_ovr_threshold),
        .fast_sel(fast_sel),
        .ovr_out(overrange_out_a)
    );

    scp_ovr_path u_ovr_b (
        .clk(clk),
        .reset(reset),
        .sample_tick(sample_tick),
        .raw_in(raw_b),
        .gain_code(gain_b),
        .threshold(fast_ovr_threshold),
        .fast_sel(fast_sel),
        .ovr_out(overrange_out_b)
    );
endmodule // scp_top

/* File: dv/scp_top_monitor.sv */
`timescale 1ns/100ps
module scp_top_monitor (
    input wire logic clk,
    input wire logic reset,
    input wire logic shift_clk,
    input wire logic port_select_low,
    input wire logic port_serial_out,
    input wire logic port_serial_out_oe_n,
    input wire logic sample_tick,
    input wire logic overrange_out_a,
    input wire logic overrange_out_b
);
    // ****
    // Port checks, all on the system clock
    // ****
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_reset_quiet: assert property ($fell(reset) |-> port_serial_out_oe_n &&
        !port_serial_out && !overrange_out_a && !overrange_out_b) else $error("not idle");
    a_oe_fall_cause: assert property ($fell(port_serial_out_oe_n) |->
        !$past(port_select_low, 2) && ($past(shift_clk, 2) || $past(shift_clk, 3)))
        else $error("readout began without a shift rise");
    a_oe_rise_cause: assert property ($rose(port_serial_out_oe_n) |-> $past(reset) ||
        (!$past(port_select_low, 2) && ($past(shift_clk, 2) || $past(shift_clk, 3))))
        else $error("readout ended without a shift rise");
    a_oe_holds: assert property ($fell(port_serial_out_oe_n) |->
        !port_serial_out_oe_n [*8]) else $error("readout dropped early");
    // Loading at readout entry is excluded, only later bit changes are timed
    a_out_on_fall: assert property (!port_serial_out_oe_n && !$past(port_serial_out_oe_n) &&
        !$past(port_serial_out_oe_n, 2) && $changed(port_serial_out) |-> !$past(shift_clk, 2))
        else $error("readout bit moved off a falling edge");
    a_select_high_quiet: assert property (port_select_low && $past(port_select_low, 3) &&
        $past(port_select_low, 6) |-> $stable(port_serial_out_oe_n) && $stable(port_serial_out))
        else $error("port reacted while deselected");
    a_ovr_a_tick: assert property ($changed(overrange_out_a) |->
        $past(sample_tick) || $past(sample_tick, 2)) else $error("flag a moved without a sample");
    a_ovr_b_tick: assert property ($changed(overrange_out_b) |->
        $past(sample_tick) || $past(sample_tick, 2)) else $error("flag b moved without a sample");
endmodule  // scp_top_monitor

bind scp_top scp_top_monitor i_mon (.clk(clk), .reset(reset), .shift_clk(shift_clk),
    .port_select_low(port_select_low), .port_serial_out(port_serial_out),
    .port_serial_out_oe_n(port_serial_out_oe_n), .sample_tick(sample_tick),
    .overrange_out_a(overrange_out_a), .overrange_out_b(overrange_out_b));

/* File: dv/scp_host.sv */
`timescale 1ns/100ps
module scp_host (
    input wire logic clk,
    output logic shift_clk,
    output logic port_select_low,
    output logic port_serial_in,
    input wire logic port_serial_out,
    input wire logic port_serial_out_oe_n
);
    logic last_q = 1'b0;
    wire sdo_line;
    // A floating line must never read back as the last driven bit
    assign sdo_line = port_serial_out_oe_n ? ~last_q : port_serial_out;
    always @(negedge clk) begin
        if (!port_serial_out_oe_n) begin
            last_q <= port_serial_out;
        end
    end
    initial begin
        shift_clk = 1'b0;
        port_select_low = 1'b1;
        port_serial_in = 1'b0;
    end
    // Four clocks of margin keep select edges clear of shift edges
    task automatic sel(input logic lvl);
        repeat (4) @(negedge clk);
        port_select_low = lvl;
        port_serial_in = ~port_serial_in;
        repeat (4) @(negedge clk);
    endtask
    task automatic shift(input logic [23:0] w, input int n, output logic [7:0] rd);
        rd = 8'h00;
        for (int i = 23; i > 23 - n; i--) begin
            port_serial_in = w[i];
            repeat (4) @(negedge clk);
            shift_clk = 1'b1;
            rd = {rd[6:0], sdo_line};
            repeat (4) @(negedge clk);
            shift_clk = 1'b0;
        end
    endtask
endmodule  // scp_host

/* File: dv/scp_top_bench.sv */
`timescale 1ns/100ps
module scp_top_bench;
    logic clk, reset, sample_tick;
    logic [15:0] raw_a, raw_b, fast_ovr_threshold;
    wire shift_clk, port_select_low, port_serial_in, port_serial_out, oe_n, ovr_a, ovr_b;
    int miscompares = 0;
    int cmp_count = 0;
    typedef struct {logic [13:0] a; logic [7:0] d; logic [7:0] e;} scp_row_t;
    // Unmapped 2031h sits before 0031h so an alias shows up as a bad reset value
    scp_row_t rows [13] = '{'{14'h0001, 8'h3c, 8'h3c}, '{14'h0003, 8'h02, 8'h02},
        '{14'h0006, 8'h02, 8'h02}, '{14'h0007, 8'h1c, 8'h1c}, '{14'h000c, 8'h0c, 8'h0c},
        '{14'h000d, 8'hc0, 8'hc0}, '{14'h000e, 8'ha5, 8'ha5}, '{14'h0015, 8'h5a, 8'h5a},
        '{14'h002b, 8'h01, 8'h01}, '{14'h0030, 8'h11, 8'h11}, '{14'h0002, 8'hff, 8'h00},
        '{14'h2031, 8'h77, 8'h00}, '{14'h0031, 8'h1f, 8'h1f}};
    scp_top i_dut (.clk(clk), .reset(reset), .shift_clk(shift_clk),
        .port_select_low(port_select_low), .port_serial_in(port_serial_in),
        .port_serial_out(port_serial_out), .port_serial_out_oe_n(oe_n),
        .sample_tick(sample_tick), .raw_a(raw_a), .raw_b(raw_b),
        .fast_ovr_threshold(fast_ovr_threshold), .overrange_out_a(ovr_a),
        .overrange_out_b(ovr_b));
    scp_host i_host (.clk(clk), .shift_clk(shift_clk), .port_select_low(port_select_low),
        .port_serial_in(port_serial_in), .port_serial_out(port_serial_out),
        .port_serial_out_oe_n(oe_n));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    function automatic logic [23:0] word(input logic rw, input logic [13:0] a,
        input logic [7:0] d);
        return {rw, 1'b1, a, d};
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic rw, input logic [13:0] a, input logic [7:0] d,
        output logic [7:0] rd);
        i_host.sel(1'b0);
        i_host.shift(word(rw, a, d), 24, rd);
        i_host.sel(1'b1);
    endtask
    task automatic wr(input logic [13:0] a, input logic [7:0] d);
        logic [7:0] rd;
        xfer(1'b0, a, d, rd);
        check({7'h00, oe_n}, 8'h01);
    endtask
    task automatic rd_chk(input logic [13:0] a, input logic [7:0] e);
        logic [7:0] rd;
        xfer(1'b1, a, 8'h00, rd);
        check(rd, e);
        check({7'h00, oe_n}, 8'h00);
    endtask
    task automatic tick(input logic [15:0] a, input logic [15:0] b);
        raw_a = a;
        raw_b = b;
        sample_tick = 1'b1;
        @(negedge clk);
        sample_tick = 1'b0;
        @(negedge clk);
    endtask
    task automatic ovr(input logic ea, input logic eb);
        check({6'h00, ovr_a, ovr_b}, {6'h00, ea, eb});
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Whole run needs about 12000 clocks
    initial begin
        #4000000;
        miscompares++;
        end_sim();
    end
    initial begin
        logic [7:0] rd;
        reset = 1'b1;
        sample_tick = 1'b0;
        raw_a = 16'h0000;
        raw_b = 16'h0000;
        fast_ovr_threshold = 16'hffff;
        repeat (12) @(negedge clk);
        reset = 1'b0;
        foreach (rows[i]) begin
            rd_chk(rows[i].a, 8'h00);
            wr(rows[i].a, rows[i].d);
            rd_chk(rows[i].a, rows[i].e);
        end
        $display("test table done");
        i_host.sel(1'b0);
        i_host.shift(word(1'b0, 14'h000e, 8'h11), 24, rd);
        i_host.shift(word(1'b0, 14'h000f, 8'h22), 24, rd);
        i_host.shift(word(1'b0, 14'h000e, 8'hff), 20, rd);
        i_host.sel(1'b1);
        rd_chk(14'h000e, 8'h11);
        xfer(1'b1, 14'h000f, 8'hee, rd);
        check(rd, 8'h22);
        rd_chk(14'h000f, 8'h22);
        i_host.shift(word(1'b0, 14'h000e, 8'h99), 24, rd);
        rd_chk(14'h000e, 8'h11);
        $display("test framing done");
        wr(14'h0006, 8'h01);
        rd_chk(14'h000e, 8'h00);
        rd_chk(14'h0006, 8'h00);
        wr(14'h000e, 8'h5a);
        rd_chk(14'h000e, 8'h5a);
        reset = 1'b1;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        check({7'h00, oe_n}, 8'h01);
        rd_chk(14'h000e, 8'h00);
        $display("test resets done");
        tick(16'h4000, 16'h3fff);
        ovr(1'b1, 1'b0);
        tick(16'h0000, 16'h0000);
        ovr(1'b0, 1'b0);
        wr(14'h0003, 8'h02);
        wr(14'h000c, 8'h01);
        tick(16'h3d00, 16'h3d00);
        ovr(1'b1, 1'b0);
        wr(14'h0004, 8'h02);
        wr(14'h000d, 8'h10);
        tick(16'h3d00, 16'h3d00);
        ovr(1'b1, 1'b1);
        tick(16'h0000, 16'h0000);
        fast_ovr_threshold = 16'h1000;
        wr(14'h0007, 8'h02);
        tick(16'h2000, 16'h2000);
        // The flagged sample reaches the pin on its ninth tick, itself counted
        repeat (7) tick(16'h0000, 16'h0000);
        ovr(1'b0, 1'b0);
        tick(16'h0000, 16'h0000);
        ovr(1'b1, 1'b1);
        $display("test overrange done");
        end_sim();
    end
endmodule  // scp_top_bench
